// File: verilog/apc_pkg.sv
// Purpose: Shared constants, types and decoders for the audio port clock and status block.
// Assumes: Registers are 32 bits wide and addressed by an 8-bit subaddress.
// Notes: Field positions are bit indices inside the clock and port configuration word.
package apc_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] SUB_CLOCK_CFG = 8'h00;
  localparam logic [7:0] SUB_STATUS = 8'h02;
  localparam logic [31:0] CLOCK_CFG_RESET = 32'h01001B22;
  // Bits 31 to 29 are unused and always read as zero.
  localparam logic [31:0] CLOCK_CFG_WMASK = 32'h1FFFFFFF;
  localparam logic [31:0] READ_ZERO = 32'h00000000;

  // ==========================================================================
  // Field positions in the configuration word
  // ==========================================================================
  localparam int FRAME_DIV_LSB = 24;
  localparam int MS_SEL_BIT = 22;
  localparam int PORT_RATIO_LSB = 19;
  localparam int MCLK_BCLK_LSB = 16;
  localparam int IN_WORD_LSB = 11;
  localparam int OUT_WORD_LSB = 8;
  localparam int IN_FMT_LSB = 4;
  localparam int OUT_FMT_LSB = 0;

  // ==========================================================================
  // Status byte
  // ==========================================================================
  localparam int NUM_MEM_TYPES = 5;
  localparam int ERR_INVALID_BIT = 5;
  localparam logic [7:0] STATUS_EOL_HDR = 8'hF0;
  localparam logic [7:0] STATUS_NO_BOOT = 8'hFF;
  localparam logic [1:0] STATUS_PAD = 2'h0;

  // ==========================================================================
  // Divider sizing
  // ==========================================================================
  localparam int DIV_W = 10;

  typedef enum logic [1:0] {
    APC_WORD_32 = 2'b00,
    APC_WORD_16 = 2'b01,
    APC_WORD_20 = 2'b10,
    APC_WORD_24 = 2'b11
  } apc_word_t;

  typedef struct packed {
    logic [3:0] channels;
    logic i2s_style;
    logic right_justified;
  } apc_fmt_t;

  // Shared by the master-clock and port-ratio dividers.
  function automatic logic [DIV_W-1:0] ratio_divisor(input logic [2:0] code);
    unique case (code)
      3'h0: ratio_divisor = 10'h001;
      3'h1: ratio_divisor = 10'h002;
      3'h2: ratio_divisor = 10'h003;
      3'h3: ratio_divisor = 10'h004;
      3'h4: ratio_divisor = 10'h006;
      3'h5: ratio_divisor = 10'h008;
      3'h6: ratio_divisor = 10'h010;
      3'h7: ratio_divisor = 10'h020;
    endcase
  endfunction

  function automatic logic [DIV_W-1:0] frame_divisor(input logic [2:0] code);
    unique case (code)
      3'h0: frame_divisor = 10'h020;
      3'h1: frame_divisor = 10'h040;
      3'h2: frame_divisor = 10'h080;
      3'h3: frame_divisor = 10'h0C0;
      3'h4: frame_divisor = 10'h100;
      3'h5: frame_divisor = 10'h180;
      3'h6: frame_divisor = 10'h200;
      3'h7: frame_divisor = 10'h020;
    endcase
  endfunction

  function automatic logic [5:0] word_bits(input apc_word_t code);
    unique case (code)
      APC_WORD_32: word_bits = 6'h20;
      APC_WORD_16: word_bits = 6'h10;
      APC_WORD_20: word_bits = 6'h14;
      APC_WORD_24: word_bits = 6'h18;
    endcase
  endfunction

  function automatic apc_fmt_t decode_format(input logic [3:0] code);
    apc_fmt_t f;
    f = '{channels: 4'h2, i2s_style: 1'b1, right_justified: 1'b0};
    unique case (code)
      4'h0: f = '{channels: 4'h2, i2s_style: 1'b0, right_justified: 1'b0};
      4'h1: f = '{channels: 4'h2, i2s_style: 1'b0, right_justified: 1'b1};
      4'h2: f = '{channels: 4'h2, i2s_style: 1'b1, right_justified: 1'b0};
      4'h3: f = '{channels: 4'h8, i2s_style: 1'b0, right_justified: 1'b0};
      4'h4: f = '{channels: 4'h6, i2s_style: 1'b0, right_justified: 1'b0};
      4'h5: f = '{channels: 4'h4, i2s_style: 1'b0, right_justified: 1'b0};
      4'h6: f = '{channels: 4'h8, i2s_style: 1'b1, right_justified: 1'b0};
      4'h7: f = '{channels: 4'h6, i2s_style: 1'b1, right_justified: 1'b0};
      4'h8: f = '{channels: 4'h4, i2s_style: 1'b1, right_justified: 1'b0};
      default: f = '{channels: 4'h2, i2s_style: 1'b1, right_justified: 1'b0};
    endcase
    return f;
  endfunction

endpackage

// File: verilog/apc_div_if.sv
// Purpose: Carrier between the top module and one tick divider.
// Assumes: All signals live in the single system clock domain.
// Notes: tick_in and tick_out are one-cycle pulses marking rising edges.
interface apc_div_if;
  import apc_pkg::*;
  logic tick_in;
  logic level_in;
  logic [DIV_W-1:0] divisor;
  logic tick_out;
  logic level_out;

  modport source (output tick_in, output level_in, output divisor,
                  input tick_out, input level_out);
  modport divider (input tick_in, input level_in, input divisor,
                   output tick_out, output level_out);
endinterface

// File: verilog/apc_divider.sv
// Purpose: Divides a stream of edge ticks by a run-time divisor and shapes a clock level.
// Assumes: Divisor is at least one; it may change at any time.
// Notes: The divided level is high for the first half of each period, rounded down.
module apc_divider (
  input wire logic clock,
  input wire logic rst_n,
  apc_div_if.divider port
);
  import apc_pkg::*;

  logic [DIV_W-1:0] count;
  logic [DIV_W-1:0] next_count;
  logic wrap;

  // ==========================================================================
  // Tick counter
  // ==========================================================================
  // Using >= lets a shrinking divisor take effect at once instead of
  // running the counter all the way round.
  always_comb begin
    wrap = (count >= port.divisor - 10'h001);
    next_count = count;
    if (port.tick_in) begin
      next_count = wrap ? '0 : count + 10'h001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

  // A divisor of one passes the source through unchanged.
  assign port.tick_out = port.tick_in & wrap;
  assign port.level_out = (port.divisor == 10'h001) ? port.level_in
                                                    : (count < (port.divisor >> 1));
endmodule

// File: verilog/apc_clock_port_ctrl.sv
// Purpose: Serial audio port clock generation, port format configuration and load status.
// Assumes: All inputs are synchronous to clock; audio clocks are far slower than clock.
// Notes: Audio clocks are rebuilt from sampled edges, so they carry one-cycle jitter.

// Function
// - Master mode frame clock divides bit clock
// - Slave mode frame pin is input
// - Port ratio divides selected bit clock
// - Slave bit clock input drives input bit clock
// - Master divides master clock into bit clock
// - Slave mode ignores master clock divider
// - Bits 12:11 set input word size
// - Bits 9:8 set output word size
// - Format nibbles; codes 0,1 left/right justified
// - Code 2 I2S; 3-5 left TDM
// - Memory select sets error; success clears it
// - Status low byte flags errors per bit
// - Special status codes F0, FF, 00
// - Select bit: one master, zero slave
module apc_clock_port_ctrl (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_sub_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic master_clock_input,
  input wire logic slave_bit_clock_in,
  input wire logic frame_clock_in,
  output logic frame_clock_out,
  output logic frame_clock_oe,
  output logic input_port_bit_clock,
  output logic output_port_bit_clock,
  output logic master_mode,
  output logic [5:0] in_word_bits,
  output logic [5:0] out_word_bits,
  output apc_pkg::apc_fmt_t in_format,
  output apc_pkg::apc_fmt_t out_format,
  input wire logic load_select_strobe,
  input wire logic [15:0] load_select_code,
  input wire logic load_ok_strobe,
  input wire logic eol_header_error,
  input wire logic no_boot_memory,
  input wire logic [23:0] firmware_status
);
  import apc_pkg::*;

  // ==========================================================================
  // Reset release
  // ==========================================================================
  logic [1:0] rst_pipe;
  logic rst_n;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rst_pipe <= 2'b00;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  // ==========================================================================
  // Configuration register
  // ==========================================================================
  logic [31:0] clock_and_port_config;
  logic [31:0] next_clock_and_port_config;
  logic [2:0] frame_div_code;
  logic [2:0] port_ratio_code;
  logic [2:0] mclk_to_bclk_code;
  logic master_slave_select;

  always_comb begin
    next_clock_and_port_config = clock_and_port_config;
    if (reg_wr && reg_sub_addr == SUB_CLOCK_CFG) begin
      next_clock_and_port_config = reg_wdata & CLOCK_CFG_WMASK;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      clock_and_port_config <= CLOCK_CFG_RESET;
    end else begin
      clock_and_port_config <= next_clock_and_port_config;
    end
  end

  assign frame_div_code = clock_and_port_config[FRAME_DIV_LSB +: 3];
  assign port_ratio_code = clock_and_port_config[PORT_RATIO_LSB +: 3];
  assign mclk_to_bclk_code = clock_and_port_config[MCLK_BCLK_LSB +: 3];
  assign master_slave_select = clock_and_port_config[MS_SEL_BIT];

  // ==========================================================================
  // Edge detection of the incoming audio clocks
  // ==========================================================================
  logic mclk_prev;
  logic sbclk_prev;
  logic next_mclk_prev;
  logic next_sbclk_prev;
  logic mclk_rise;
  logic sbclk_rise;

  always_comb begin
    next_mclk_prev = master_clock_input;
    next_sbclk_prev = slave_bit_clock_in;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mclk_prev <= 1'b0;
      sbclk_prev <= 1'b0;
    end else begin
      mclk_prev <= next_mclk_prev;
      sbclk_prev <= next_sbclk_prev;
    end
  end

  assign mclk_rise = master_clock_input & ~mclk_prev;
  assign sbclk_rise = slave_bit_clock_in & ~sbclk_prev;

  // ==========================================================================
  // Divider chain
  // ==========================================================================
  apc_div_if bclk_div ();
  apc_div_if ratio_div ();
  apc_div_if frame_div ();

  logic selected_tick;
  logic selected_bit_clock;

  // The master-clock divider only sees ticks in master mode, so its code
  // cannot disturb anything while the bit clock comes from outside.
  assign bclk_div.tick_in = mclk_rise & master_slave_select;
  assign bclk_div.level_in = master_clock_input;
  assign bclk_div.divisor = ratio_divisor(mclk_to_bclk_code);

  apc_divider u_bclk_div (
    .clock(clock),
    .rst_n(rst_n),
    .port(bclk_div)
  );

  always_comb begin
    if (master_slave_select) begin
      selected_tick = bclk_div.tick_out;
      selected_bit_clock = bclk_div.level_out;
    end else begin
      selected_tick = sbclk_rise;
      selected_bit_clock = slave_bit_clock_in;
    end
  end

  // A nonzero port ratio is only meaningful when input and output rates
  // differ; the hardware divides whatever the field holds.
  assign ratio_div.tick_in = selected_tick;
  assign ratio_div.level_in = selected_bit_clock;
  assign ratio_div.divisor = ratio_divisor(port_ratio_code);

  apc_divider u_ratio_div (
    .clock(clock),
    .rst_n(rst_n),
    .port(ratio_div)
  );

  assign frame_div.tick_in = selected_tick & master_slave_select;
  assign frame_div.level_in = selected_bit_clock;
  assign frame_div.divisor = frame_divisor(frame_div_code);

  apc_divider u_frame_div (
    .clock(clock),
    .rst_n(rst_n),
    .port(frame_div)
  );

  // ==========================================================================
  // Clock and format outputs
  // ==========================================================================
  logic next_frame_clock_out;
  logic next_frame_clock_oe;
  logic next_input_port_bit_clock;
  logic next_output_port_bit_clock;
  logic [5:0] next_in_word_bits;
  logic [5:0] next_out_word_bits;
  apc_fmt_t next_in_format;
  apc_fmt_t next_out_format;

  always_comb begin
    next_frame_clock_oe = master_slave_select;
    next_frame_clock_out = master_slave_select ? frame_div.level_out : 1'b0;
    next_input_port_bit_clock = selected_bit_clock;
    next_output_port_bit_clock = ratio_div.level_out;
    next_in_word_bits = word_bits(apc_word_t'(clock_and_port_config[IN_WORD_LSB +: 2]));
    next_out_word_bits = word_bits(apc_word_t'(clock_and_port_config[OUT_WORD_LSB +: 2]));
    next_in_format = decode_format(clock_and_port_config[IN_FMT_LSB +: 4]);
    next_out_format = decode_format(clock_and_port_config[OUT_FMT_LSB +: 4]);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      frame_clock_out <= 1'b0;
      frame_clock_oe <= 1'b0;
      input_port_bit_clock <= 1'b0;
      output_port_bit_clock <= 1'b0;
      master_mode <= 1'b0;
      in_word_bits <= 6'h00;
      out_word_bits <= 6'h00;
      in_format <= '0;
      out_format <= '0;
    end else begin
      frame_clock_out <= next_frame_clock_out;
      frame_clock_oe <= next_frame_clock_oe;
      input_port_bit_clock <= next_input_port_bit_clock;
      output_port_bit_clock <= next_output_port_bit_clock;
      master_mode <= master_slave_select;
      in_word_bits <= next_in_word_bits;
      out_word_bits <= next_out_word_bits;
      in_format <= next_in_format;
      out_format <= next_out_format;
    end
  end

  // ==========================================================================
  // Download error status
  // ==========================================================================
  logic [ERR_INVALID_BIT:0] load_err;
  logic [ERR_INVALID_BIT:0] next_load_err;
  logic [2:0] load_mem;
  logic [2:0] next_load_mem;
  logic load_active;
  logic next_load_active;
  logic eol_err;
  logic next_eol_err;
  logic [ERR_INVALID_BIT:0] err_set;
  logic [ERR_INVALID_BIT:0] err_clr;
  logic select_valid;
  logic [7:0] status_low;

  // A selection that lands in the same cycle as a completion wins, so a
  // fresh load is never reported clean by accident.
  always_comb begin
    select_valid = (load_select_code < 16'(NUM_MEM_TYPES));
    err_set = '0;
    err_clr = '0;
    next_load_mem = load_mem;
    next_load_active = load_active;
    next_eol_err = eol_err | eol_header_error;
    if (load_ok_strobe && load_active) begin
      err_clr[load_mem] = 1'b1;
      next_load_active = 1'b0;
    end
    if (load_select_strobe) begin
      next_eol_err = eol_header_error;
      if (select_valid) begin
        err_set[load_select_code[2:0]] = 1'b1;
        err_clr[ERR_INVALID_BIT] = 1'b1;
        next_load_mem = load_select_code[2:0];
        next_load_active = 1'b1;
      end else begin
        err_set[ERR_INVALID_BIT] = 1'b1;
        next_load_active = 1'b0;
      end
    end
    next_load_err = (load_err & ~err_clr) | err_set;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      load_err <= '0;
      load_mem <= 3'h0;
      load_active <= 1'b0;
      eol_err <= 1'b0;
    end else begin
      load_err <= next_load_err;
      load_mem <= next_load_mem;
      load_active <= next_load_active;
      eol_err <= next_eol_err;
    end
  end

  always_comb begin
    if (no_boot_memory) begin
      status_low = STATUS_NO_BOOT;
    end else if (eol_err) begin
      status_low = STATUS_EOL_HDR;
    end else begin
      status_low = {STATUS_PAD, load_err};
    end
  end

  // ==========================================================================
  // Register read port
  // ==========================================================================
  logic [31:0] next_reg_rdata;
  logic next_reg_rvalid;

  // Unmapped subaddresses answer with zero so a stray read never stalls.
  always_comb begin
    next_reg_rvalid = reg_rd;
    next_reg_rdata = reg_rdata;
    if (reg_rd) begin
      unique case (reg_sub_addr)
        SUB_CLOCK_CFG: next_reg_rdata = clock_and_port_config;
        SUB_STATUS: next_reg_rdata = {firmware_status, status_low};
        default: next_reg_rdata = READ_ZERO;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= READ_ZERO;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rdata <= next_reg_rdata;
      reg_rvalid <= next_reg_rvalid;
    end
  end

endmodule

// File: tb/apc_clock_port_ctrl_monitor.sv
// Purpose: Port-level checks of the audio port clock and status block.
// Assumes: One clock domain; reset_n is the raw asynchronous reset.
// Notes: Bound to every instance of the top module.
module apc_clock_port_ctrl_monitor
  import apc_pkg::*;
(
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [7:0] reg_sub_addr,
  input wire logic reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic slave_bit_clock_in,
  input wire logic frame_clock_out,
  input wire logic frame_clock_oe,
  input wire logic input_port_bit_clock,
  input wire logic master_mode,
  input wire logic [5:0] in_word_bits,
  input wire logic [5:0] out_word_bits,
  input wire apc_pkg::apc_fmt_t in_format,
  input wire logic no_boot_memory
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [2:0] slave_cnt;
  logic [2:0] next_slave_cnt;
  // =====
  // Helper
  // A mode change reroutes the bit clock, so the pipe needs time to settle.
  always_comb begin
    next_slave_cnt = slave_cnt;
    if (master_mode) next_slave_cnt = 3'h0;
    else if (slave_cnt != 3'h7) next_slave_cnt = slave_cnt + 3'h1;
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) slave_cnt <= 3'h0;
    else slave_cnt <= next_slave_cnt;
  end
  // =====
  // Properties
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  a_slave_no_drive: assert property (!master_mode && !$past(master_mode)
    |-> !frame_clock_oe && !frame_clock_out) else $error("frame pin driven in slave mode");
  a_master_drives: assert property (master_mode && $past(master_mode)
    |-> frame_clock_oe) else $error("frame pin not driven in master mode");
  a_slave_bclk_path: assert property (slave_cnt >= 3'h6
    |-> input_port_bit_clock == $past(slave_bit_clock_in, 1)) else $error("slave bit clock lost");
  a_in_word_16: assert property ((reg_wr && reg_sub_addr == SUB_CLOCK_CFG
    && reg_wdata[12:11] == 2'b01) ##1 (!reg_wr)[*3] |-> in_word_bits == 6'h10)
    else $error("input word size not 16");
  a_out_word_20: assert property ((reg_wr && reg_sub_addr == SUB_CLOCK_CFG
    && reg_wdata[9:8] == 2'b10) ##1 (!reg_wr)[*3] |-> out_word_bits == 6'h14)
    else $error("output word size not 20");
  a_in_fmt_left: assert property ((reg_wr && reg_sub_addr == SUB_CLOCK_CFG
    && reg_wdata[7:4] == 4'h0) ##1 (!reg_wr)[*3] |-> in_format == 6'h08)
    else $error("input format not two-channel left");
  a_mode_select: assert property ((reg_wr && reg_sub_addr == SUB_CLOCK_CFG)
    ##1 (!reg_wr)[*3] |-> master_mode == $past(reg_wdata[22], 3))
    else $error("mode does not follow select bit");
  a_no_boot_code: assert property (reg_rd && reg_sub_addr == SUB_STATUS
    && no_boot_memory && $past(no_boot_memory, 2) |=> reg_rdata[7:0] == 8'hFF)
    else $error("status low byte not FF");
endmodule

bind apc_clock_port_ctrl apc_clock_port_ctrl_monitor mon_u (.clock, .reset_n, .reg_sub_addr,
  .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .slave_bit_clock_in, .frame_clock_out,
  .frame_clock_oe, .input_port_bit_clock, .master_mode, .in_word_bits, .out_word_bits,
  .in_format, .no_boot_memory);

// File: tb/apc_audio_clocks.sv
// Purpose: Behavioural converter clocks on the far side of the port block.
// Assumes: Converter clocks run free, as real ones do.
// Notes: Half periods are counted in system clock cycles.
module apc_audio_clocks #(
  parameter int MCLK_HALF = 2,
  parameter int SCLK_HALF = 3
) (
  input wire logic clock,
  output logic master_clock_input,
  output logic slave_bit_clock_in,
  output logic frame_clock_in
);
  timeunit 1ns;
  timeprecision 100ps;
  int mc = 0;
  int sc = 0;
  int fc = 0;
  initial begin
    master_clock_input = 1'b0;
    slave_bit_clock_in = 1'b0;
    frame_clock_in = 1'b0;
  end
  // A slave frame of 64 bit clocks, so 64 half periods per frame half.
  always @(posedge clock) begin
    mc = (mc + 1) % MCLK_HALF;
    sc = (sc + 1) % SCLK_HALF;
    if (mc == 0) master_clock_input <= !master_clock_input;
    if (sc == 0) fc = (fc + 1) % 64;
    if (sc == 0) slave_bit_clock_in <= !slave_bit_clock_in;
    if (sc == 0 && fc == 0) frame_clock_in <= !frame_clock_in;
  end
endmodule

// File: tb/apc_clock_port_ctrl_tb.sv
// Purpose: Self-checking bench for the audio port clock and status block.
// Assumes: Converter clocks come from the behavioural clock source.
// Notes: A clock period is measured between its second and third rising edges.
module apc_clock_port_ctrl_tb import apc_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int MH = 2;
  localparam int SH = 3;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic [7:0] reg_sub_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_wdata = 32'h0;
  logic load_select_strobe = 1'b0;
  logic load_ok_strobe = 1'b0;
  logic eol_header_error = 1'b0;
  logic no_boot_memory = 1'b0;
  logic [15:0] load_select_code = 16'h0;
  logic [23:0] firmware_status = 24'h0;
  logic [31:0] reg_rdata;
  logic reg_rvalid, master_clock_input, slave_bit_clock_in, frame_clock_in;
  logic frame_clock_out, frame_clock_oe, input_port_bit_clock, output_port_bit_clock;
  logic master_mode;
  logic [5:0] in_word_bits, out_word_bits;
  apc_fmt_t in_format, out_format;
  logic [31:0] cfg_m;
  logic [5:0] err_m;
  logic eol_m;
  int act_m, p;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 32'h0315;
  int rdv[8] = '{1, 2, 3, 4, 6, 8, 16, 32};
  int fdv[8] = '{32, 64, 128, 192, 256, 384, 512, 32};
  int wbv[4] = '{32, 16, 20, 24};

  apc_clock_port_ctrl dut_u (.clock, .reset_n, .reg_sub_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .reg_rvalid, .master_clock_input, .slave_bit_clock_in, .frame_clock_in,
    .frame_clock_out, .frame_clock_oe, .input_port_bit_clock, .output_port_bit_clock,
    .master_mode, .in_word_bits, .out_word_bits, .in_format, .out_format, .load_select_strobe,
    .load_select_code, .load_ok_strobe, .eol_header_error, .no_boot_memory, .firmware_status);
  apc_audio_clocks #(.MCLK_HALF(MH), .SCLK_HALF(SH)) src_u (.clock, .master_clock_input,
    .slave_bit_clock_in, .frame_clock_in);

  always #2.5 clock = ~clock;
  // =====
  // Helpers
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  function automatic logic [31:0] cw(input int fr, ms, x, z, iw, ow, im, om);
    return 32'((fr << FRAME_DIV_LSB) | (ms << MS_SEL_BIT) | (x << PORT_RATIO_LSB)
      | (z << MCLK_BCLK_LSB) | (iw << IN_WORD_LSB) | (ow << OUT_WORD_LSB) | (im << 4) | om);
  endfunction
  function automatic apc_fmt_t fe(input int c);
    fe = '{4'h2, 1'b1, 1'b0};
    if (c < 2) fe = '{4'h2, 1'b0, 1'(c)};
    if (c > 2 && c < 9) fe = '{4'(8 - 2 * ((c - 3) % 3)), 1'(c > 5), 1'b0};
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_sub_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    if (a == SUB_CLOCK_CFG) cfg_m = d & 32'h1FFFFFFF;
    tick(4);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_sub_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rvalid", 32'h1, 32'(reg_rvalid));
    chk(nm, e, reg_rdata);
  endtask
  task automatic rds();
    logic [7:0] lo;
    lo = no_boot_memory ? 8'hFF : (eol_m ? 8'hF0 : {2'b00, err_m});
    rd(SUB_STATUS, {firmware_status, lo}, "status");
  endtask
  // Kind 0 selects a memory, 1 reports a good load, 2 reports a header error.
  task automatic pls(input int k, input int c);
    @(posedge clock);
    load_select_code <= 16'(c);
    load_select_strobe <= (k == 0);
    load_ok_strobe <= (k == 1);
    eol_header_error <= (k == 2);
    @(posedge clock);
    load_select_strobe <= 1'b0;
    load_ok_strobe <= 1'b0;
    eol_header_error <= 1'b0;
    if (k == 0) begin
      eol_m = 1'b0;
      err_m[5] = (c > 4);
      if (c < 5) err_m[c] = 1'b1;
      act_m = (c < 5) ? c : -1;
    end else if (k == 1 && act_m >= 0) err_m[act_m] = 1'b0;
    else if (k == 2) eol_m = 1'b1;
  endtask
  task automatic outs();
    chk("in_word_bits", 32'(wbv[cfg_m[12:11]]), 32'(in_word_bits));
    chk("out_word_bits", 32'(wbv[cfg_m[9:8]]), 32'(out_word_bits));
    chk("in_format", 32'(fe(cfg_m[7:4])), 32'(in_format));
    chk("out_format", 32'(fe(cfg_m[3:0])), 32'(out_format));
    chk("master_mode", 32'(cfg_m[22]), 32'(master_mode));
    chk("frame_clock_oe", 32'(cfg_m[22]), 32'(frame_clock_oe));
  endtask
  task automatic per(input int w, output int p);
    int t = 0;
    int c = 0;
    int st = 0;
    logic v;
    logic pv = 1'b1;
    p = -1;
    while (c < 3 && t < 9000) begin
      tick(1);
      t++;
      v = (w == 0) ? input_port_bit_clock : (w == 1) ? output_port_bit_clock : frame_clock_out;
      if (v === 1'b1 && pv === 1'b0) c++;
      if (v === 1'b1 && pv === 1'b0 && c == 2) st = t;
      if (v === 1'b1 && pv === 1'b0 && c == 3) p = t - st;
      pv = v;
    end
  endtask
  task automatic init_model();
    cfg_m = 32'h01001B22;
    err_m = 6'h00;
    eol_m = 1'b0;
    act_m = -1;
  endtask
  // =====
  // Sequence
  always @(posedge clock) begin
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      complete_run();
    end
  end
  initial begin
    init_model();
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    tick(4);
    outs();
    rd(SUB_CLOCK_CFG, cfg_m, "config");
    rds();
    rd(8'h01, 32'h0, "unmapped");
    for (int i = 0; i < 4; i++) begin
      wr(SUB_CLOCK_CFG, 32'($random(seed)));
      rd(SUB_CLOCK_CFG, cfg_m, "config");
      outs();
    end
    for (int i = 0; i < 16; i++) begin
      wr(SUB_CLOCK_CFG, cw(1, 0, 0, i % 8, i % 4, (i + 1) % 4, i, 15 - i));
      outs();
      per(0, p);
      chk("slave bit clock period", 32'(2 * SH), 32'(p));
    end
    for (int i = 0; i < 8; i++) begin
      wr(SUB_CLOCK_CFG, cw(7, 1, 0, i, 3, 3, 2, 2));
      outs();
      per(0, p);
      chk("bit clock period", 32'(2 * MH * rdv[i]), 32'(p));
      wr(SUB_CLOCK_CFG, cw(i, 1, i, 0, 3, 3, 2, 2));
      per(1, p);
      chk("port clock period", 32'(2 * MH * rdv[i]), 32'(p));
      per(2, p);
      chk("frame period", 32'(2 * MH * fdv[i]), 32'(p));
    end
    wr(SUB_CLOCK_CFG, cw(2, 0, 3, 5, 3, 3, 2, 2));
    per(1, p);
    chk("slave port clock period", 32'(2 * SH * 4), 32'(p));
    chk("frame_clock_out", 32'h0, 32'(frame_clock_out));
    @(posedge clock);
    firmware_status <= 24'($random(seed));
    for (int i = 0; i < 5; i++) begin
      pls(0, i);
      rds();
      pls(1, 0);
      rds();
    end
    pls(0, 9);
    rds();
    pls(0, 3);
    rds();
    pls(0, 1);
    pls(1, 0);
    rds();
    pls(2, 0);
    rds();
    pls(0, 0);
    rds();
    @(posedge clock);
    no_boot_memory <= 1'b1;
    tick(3);
    rds();
    @(posedge clock);
    no_boot_memory <= 1'b0;
    wr(SUB_STATUS, 32'hFFFFFFFF);
    rds();
    @(posedge clock);
    reset_n <= 1'b0;
    repeat (3) @(posedge clock);
    reset_n <= 1'b1;
    init_model();
    tick(4);
    rd(SUB_CLOCK_CFG, cfg_m, "config");
    rds();
    complete_run();
  end
endmodule
